// ==== logic/apm_cfg.svh ====
// timing counts, field positions and reset values of the power-mode control block
`ifndef APM_CFG_SVH
`define APM_CFG_SVH
// ---------------------------------------------------------------
// frame geometry
// ---------------------------------------------------------------
`define APM_FRAME_BITS 16
`define APM_CTRL_BITS 12
`define APM_TRACK_EDGE 14
// ---------------------------------------------------------------
// control word fields (bit 11 is the first bit shifted in)
// ---------------------------------------------------------------
`define APM_F_WRITE 11
`define APM_F_SEQ 10
`define APM_F_ADDR_HI 8
`define APM_F_ADDR_LO 6
`define APM_F_PM_HI 5
`define APM_F_PM_LO 4
`define APM_F_MASK_SEL 3
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define APM_CTRL_RST 12'hfff
`define APM_MASK_RST 16'h0000
`define APM_WAKE_NS 1000
`define APM_CLK_NS 10
`define APM_WAKE_CYC ((`APM_WAKE_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`endif

// ==== logic/apm_edge_sync.sv ====
// two-flop synchroniser with edge detect for the serial link pins
`timescale 1ns/10ps
`default_nettype none
module apm_edge_sync #(
    parameter int W = 3
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    s1_r[g] <= 1'b1;
                    s2_r[g] <= 1'b1;
                    s3_r[g] <= 1'b1;
                end else if (ce_i) begin
                    s1_r[g] <= d_i[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                end
            end
            assign q_o[g] = s2_r[g];
            assign rise_o[g] = s2_r[g] & ~s3_r[g];
            assign fall_o[g] = ~s2_r[g] & s3_r[g];
        end
    endgenerate
endmodule // apm_edge_sync
`default_nettype wire

// ==== logic/apm_pkg.sv ====
// types of the power-mode control block
`default_nettype none
package apm_pkg;
    typedef enum logic [1:0] {
        APM_PM_AUTO = 2'h1,
        APM_PM_FULL = 2'h2,
        APM_PM_NORM = 2'h3
    } apm_pm_t;
    typedef enum logic [1:0] {
        APM_ST_IDLE = 2'h0,
        APM_ST_FRAME = 2'h1,
        APM_ST_DONE = 2'h3
    } apm_state_t;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } apm_link_t;
    typedef struct packed {
        logic powered;
        logic hold;
        logic waking;
    } apm_status_t;
endpackage
`default_nettype wire

// ==== logic/apm_power_ctrl.sv ====
// power-mode control and serial frame handling of the converter
`timescale 1ns/10ps
`default_nettype none
`include "apm_cfg.svh"
module apm_power_ctrl
    import apm_pkg::*;
#(
    parameter int RES_BITS = 12,
    parameter int WAKE_CYC = `APM_WAKE_CYC
) (
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    // serial link pins
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic DIN_I,
    output logic DOUT_O,
    output logic DOUT_OE_O,
    // conversion result from the analog core
    input wire logic [RES_BITS-1:0] RESULT_I,
    // status
    output logic POWERED_O,
    output logic HOLD_O,
    output logic WAKING_O,
    output logic [1:0] POWER_MODE_O,
    output logic [2:0] CHANNEL_ADDR_O,
    output logic SEQUENCE_ENABLE_O,
    output logic [15:0] CHANNEL_MASK_O,
    output logic FRAME_DONE_O
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    apm_link_t pin_q, pin_rise, pin_fall;
    apm_edge_sync #(.W(3)) u_sync (
        .clk_i(MCLK_I),
        .nrst_i(NRST_I),
        .ce_i(CE_I),
        .d_i({CS_N_I, SCLK_I, DIN_I}),
        .q_o(pin_q),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );
    wire cs_fall = pin_fall.cs_n;
    wire cs_rise = pin_rise.cs_n;
    wire sclk_fall = pin_fall.sclk & ~pin_q.cs_n;

    // ---------------------------------------------------------------
    // frame state
    // ---------------------------------------------------------------
    apm_state_t state_r;
    logic [4:0] edge_cnt_r;
    logic [15:0] shift_in_r;
    logic [15:0] shift_out_r;
    logic [11:0] ctrl_r;
    logic [15:0] mask_r;
    logic mask_next_r;
    logic mask_frame_r;
    logic [1:0] pm_r;
    logic powered_r;
    logic hold_r;
    logic [$clog2(WAKE_CYC+1)-1:0] wake_cnt_r;
    logic frame_done_r;
    logic dout_r;
    logic dout_oe_r;
    wire [4:0] frame_bits = 5'(`APM_FRAME_BITS);
    wire frame_full = (edge_cnt_r == frame_bits);
    wire [15:0] result_word;

    // result word layout
    assign result_word = {1'b0, ctrl_r[`APM_F_ADDR_HI:`APM_F_ADDR_LO], RESULT_I,
                          {(12 - RES_BITS){1'b0}}};

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            state_r <= APM_ST_IDLE;
        end else if (CE_I) begin
            case (state_r)
                APM_ST_IDLE: if (cs_fall) state_r <= APM_ST_FRAME;
                APM_ST_FRAME: begin
                    if (cs_rise) state_r <= frame_full ? APM_ST_DONE : APM_ST_IDLE;
                end
                APM_ST_DONE: state_r <= APM_ST_IDLE;
                default: state_r <= APM_ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // shifting and result output
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            edge_cnt_r <= 5'h00;
            shift_in_r <= 16'h0000;
        end else if (CE_I) begin
            if (cs_fall) begin
                edge_cnt_r <= 5'h00;
            end else if (state_r == APM_ST_FRAME && sclk_fall && !frame_full) begin
                edge_cnt_r <= edge_cnt_r + 5'h01;
                shift_in_r <= {shift_in_r[14:0], pin_q.din};
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            shift_out_r <= 16'h0000;
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
        end else if (CE_I) begin
            if (cs_fall) begin
                shift_out_r <= {result_word[14:0], 1'b0};
                dout_r <= 1'b0;
                dout_oe_r <= 1'b1;
            end else if (cs_rise) begin
                dout_oe_r <= 1'b0;
            end else if (state_r == APM_ST_FRAME && sclk_fall) begin
                dout_r <= shift_out_r[15];
                shift_out_r <= {shift_out_r[14:0], 1'b0};
                if (edge_cnt_r == frame_bits - 5'h01) dout_oe_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // control word and channel mask
    // ---------------------------------------------------------------
    wire frame_ok = (state_r == APM_ST_FRAME) && cs_rise && frame_full;
    wire [11:0] ctrl_in = shift_in_r[15:4];
    wire ctrl_wr = frame_ok && !mask_frame_r && ctrl_in[`APM_F_WRITE];

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            ctrl_r <= `APM_CTRL_RST;
            mask_r <= `APM_MASK_RST;
            mask_next_r <= 1'b0;
            mask_frame_r <= 1'b0;
        end else if (CE_I) begin
            if (cs_fall) mask_frame_r <= mask_next_r;
            if (frame_ok && mask_frame_r) begin
                mask_r <= shift_in_r;
                mask_next_r <= 1'b0;
            end else if (ctrl_wr) begin
                ctrl_r <= ctrl_in;
                mask_next_r <= !ctrl_in[`APM_F_SEQ] && ctrl_in[`APM_F_MASK_SEL];
            end
        end
    end

    // ---------------------------------------------------------------
    // power mode, power state and track-and-hold
    // ---------------------------------------------------------------
    wire [1:0] pm_new = {ctrl_in[`APM_F_PM_HI], ctrl_in[`APM_F_PM_LO]};
    wire track_edge = sclk_fall && (edge_cnt_r == 5'(`APM_TRACK_EDGE - 1)) && !mask_frame_r;

    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            pm_r <= APM_PM_NORM;
            powered_r <= 1'b1;
            hold_r <= 1'b0;
            wake_cnt_r <= '0;
            frame_done_r <= 1'b0;
        end else if (CE_I) begin
            frame_done_r <= frame_ok;
            if (wake_cnt_r != '0) wake_cnt_r <= wake_cnt_r - 1'b1;
            if (cs_fall) begin
                hold_r <= 1'b1;
                if (pm_r == APM_PM_AUTO && !powered_r) begin
                    hold_r <= 1'b0;
                    powered_r <= 1'b1;
                    wake_cnt_r <= ($clog2(WAKE_CYC+1))'(WAKE_CYC);
                end
            end else if (state_r == APM_ST_FRAME && track_edge) begin
                hold_r <= 1'b0;
            end else if (frame_ok && mask_frame_r) begin
                hold_r <= 1'b0;
            end
            if (frame_ok) begin
                if (ctrl_wr) pm_r <= pm_new;
                case (ctrl_wr ? pm_new : pm_r)
                    APM_PM_NORM: begin
                        if (!powered_r) wake_cnt_r <= ($clog2(WAKE_CYC+1))'(WAKE_CYC);
                        powered_r <= 1'b1;
                    end
                    APM_PM_FULL: begin
                        powered_r <= 1'b0;
                        hold_r <= 1'b1;
                    end
                    APM_PM_AUTO: begin
                        powered_r <= 1'b0;
                        hold_r <= 1'b1;
                    end
                    default: powered_r <= powered_r;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            DOUT_O <= 1'b0;
            DOUT_OE_O <= 1'b0;
            POWERED_O <= 1'b1;
            HOLD_O <= 1'b0;
            WAKING_O <= 1'b0;
            POWER_MODE_O <= 2'h3;
            CHANNEL_ADDR_O <= 3'h7;
            SEQUENCE_ENABLE_O <= 1'b1;
            CHANNEL_MASK_O <= 16'h0000;
            FRAME_DONE_O <= 1'b0;
        end else if (CE_I) begin
            DOUT_O <= dout_r;
            DOUT_OE_O <= dout_oe_r;
            POWERED_O <= powered_r;
            HOLD_O <= hold_r;
            WAKING_O <= (wake_cnt_r != '0);
            POWER_MODE_O <= pm_r;
            CHANNEL_ADDR_O <= ctrl_r[`APM_F_ADDR_HI:`APM_F_ADDR_LO];
            SEQUENCE_ENABLE_O <= ctrl_r[`APM_F_SEQ];
            CHANNEL_MASK_O <= mask_r;
            FRAME_DONE_O <= frame_done_r;
        end
    end
endmodule // apm_power_ctrl
`default_nettype wire

// ==== verification/apm_host_model.sv ====
// serial master model driving the converter link
`timescale 1ns/10ps
`default_nettype none
module apm_host_model (
    // clock and link
    input wire logic clk_i,
    input wire logic dout_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_o = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            din_o = w[15-i];
            half();
            rx[15-i] = dout_i;
            sclk_o = 1'b0;
            half();
            sclk_o = 1'b1;
        end
        half();
        cs_n_o = 1'b1;
        din_o = ~din_o;
    endtask
endmodule // apm_host_model
`default_nettype wire

// ==== verification/apm_power_ctrl_sva.sv ====
// assertions on the power-mode control ports
`timescale 1ns/10ps
`default_nettype none
module apm_power_ctrl_sva #(
    parameter int RES_BITS = 12,
    parameter int WAKE_CYC = 4
) (
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    // serial link
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic DIN_I,
    input wire logic DOUT_O,
    input wire logic DOUT_OE_O,
    input wire logic [RES_BITS-1:0] RESULT_I,
    // status
    input wire logic POWERED_O,
    input wire logic HOLD_O,
    input wire logic WAKING_O,
    input wire logic [1:0] POWER_MODE_O,
    input wire logic [2:0] CHANNEL_ADDR_O,
    input wire logic SEQUENCE_ENABLE_O,
    input wire logic [15:0] CHANNEL_MASK_O,
    input wire logic FRAME_DONE_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    a_cs_fall_hold: assert property ($fell(CS_N_I) && !DOUT_OE_O && POWER_MODE_O == 2'h3 |-> ##[2:5] HOLD_O && DOUT_OE_O)
        else $error("no hold at frame start");
    a_lead_zero: assert property ($rose(DOUT_OE_O) |-> !DOUT_O)
        else $error("first output bit not zero");
    a_oe_release: assert property ($rose(CS_N_I) |-> ##[2:6] !DOUT_OE_O)
        else $error("output not released");
    a_mode_done: assert property (!$stable(POWER_MODE_O) |-> ##[0:2] FRAME_DONE_O)
        else $error("mode changed without complete frame");
    a_mask_done: assert property (!$stable(CHANNEL_MASK_O) |-> ##[0:2] FRAME_DONE_O)
        else $error("mask changed without complete frame");
    a_ctrl_done: assert property (!$stable({CHANNEL_ADDR_O, SEQUENCE_ENABLE_O}) |-> ##[0:2] FRAME_DONE_O)
        else $error("control changed without complete frame");
    a_norm_up: assert property (FRAME_DONE_O && POWER_MODE_O == 2'h3 |-> POWERED_O)
        else $error("not powered in normal mode");
    a_auto_down: assert property (FRAME_DONE_O && POWER_MODE_O == 2'h1 && $past(POWER_MODE_O, 2) != 2'h1
        |-> !POWERED_O && HOLD_O)
        else $error("auto shutdown not entered");
    a_auto_wake: assert property ($fell(CS_N_I) && POWER_MODE_O == 2'h1 && !POWERED_O |-> ##[2:5] POWERED_O && !HOLD_O)
        else $error("no wake from auto shutdown");
    a_full_stays: assert property ($fell(CS_N_I) && POWER_MODE_O == 2'h2 |-> ##6 !POWERED_O)
        else $error("full shutdown left by frame start");
    c_auto: cover property (FRAME_DONE_O && POWER_MODE_O == 2'h1);
    c_wake: cover property ($rose(WAKING_O));
    c_mask: cover property (!$stable(CHANNEL_MASK_O));
endmodule // apm_power_ctrl_sva
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the power-mode control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, sclk, din, dout, dout_oe, powered, hold, waking, frame_done, seq_en;
    logic [11:0] result = 12'h000;
    logic [1:0] pm;
    logic [2:0] addr;
    logic [15:0] mask;
    int num_errors = 0;
    int compares = 0;
    logic [2:0] e_addr = 3'h7;
    logic [1:0] e_pm = 2'h3;
    logic [15:0] e_mask = 16'h0000;
    logic e_seq = 1'b1;
    logic arm = 1'b0;
    always #5 clk = ~clk;
    apm_power_ctrl #(.RES_BITS(12), .WAKE_CYC(4)) u_dut (
        .MCLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .CS_N_I(cs_n), .SCLK_I(sclk), .DIN_I(din),
        .DOUT_O(dout), .DOUT_OE_O(dout_oe), .RESULT_I(result), .POWERED_O(powered), .HOLD_O(hold),
        .WAKING_O(waking), .POWER_MODE_O(pm), .CHANNEL_ADDR_O(addr), .SEQUENCE_ENABLE_O(seq_en),
        .CHANNEL_MASK_O(mask), .FRAME_DONE_O(frame_done));
    apm_host_model u_host (.clk_i(clk), .dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [15:0] mk(input logic s, input logic [2:0] a, input logic [1:0] p, input logic m);
        return {1'b1, s, 1'b0, a, p, m, 3'($urandom), 4'($urandom)};
    endfunction
    task automatic frame(input logic [15:0] w, input int n);
        logic [15:0] rx;
        logic [15:0] exp;
        int i;
        result = 12'($urandom);
        exp = {1'b0, e_addr, result};
        u_host.xfer(w, n, rx);
        for (i = 0; i < 40 && frame_done !== 1'b1 && n == 16; i++)
            @(negedge clk);
        if (i == 40) begin
            num_errors++;
            $display("Error at %0t: frame end not seen", $time);
            give_verdict();
        end
        if (n != 16)
            repeat (8) @(negedge clk);
        if (n == 16 && e_pm == 2'h3)
            check(rx, exp);
        if (n == 16 && arm) begin
            e_mask = w;
            arm = 1'b0;
        end else if (n == 16 && w[15]) begin
            e_seq = w[14];
            e_addr = w[12:10];
            e_pm = w[9:8];
            arm = !w[14] && w[7];
        end
        check(16'(addr), 16'(e_addr));
        check(16'(seq_en), 16'(e_seq));
        check(16'(pm), 16'(e_pm));
        check(mask, e_mask);
        check(16'(dout_oe), 16'h0000);
        check(16'({powered, hold}), 16'({e_pm == 2'h3, e_pm != 2'h3 || n != 16}));
        repeat (8) @(negedge clk);
    endtask
    initial begin
        int seed;
        seed = $urandom(32'hae524d68);
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        check(16'({powered, hold, waking, frame_done, pm, addr, seq_en}), 16'h023f);
        frame(16'hffff, 16);
        frame(16'hffff, 16);
        frame(mk(1'b1, 3'($urandom), 2'h3, 1'b0), 16);
        for (int k = 0; k < 6; k++)
            frame(mk(1'b1, 3'($urandom), 2'h3, 1'($urandom)), 16);
        frame({1'b0, 15'($urandom)}, 16);
        frame(mk(1'b1, ~e_addr, 2'h2, 1'b0), 10);
        frame(mk(1'b0, e_addr, 2'h3, 1'b1), 16);
        frame(16'($urandom), 16);
        frame(mk(1'b1, 3'h0, 2'h2, 1'b0), 16);
        frame({1'b0, 15'($urandom)}, 16);
        frame(mk(1'b1, 3'h5, 2'h3, 1'b0), 16);
        frame(mk(1'b1, 3'h2, 2'h1, 1'b0), 16);
        frame({1'b0, 15'($urandom)}, 16);
        frame(mk(1'b1, 3'h2, 2'h3, 1'b0), 16);
        // mid-run reset, then short power-up sequence
        nrst = 1'b0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        e_addr = 3'h7;
        e_pm = 2'h3;
        e_mask = 16'h0000;
        e_seq = 1'b1;
        arm = 1'b0;
        repeat (3) @(negedge clk);
        check(16'({powered, hold, waking, frame_done, pm, addr, seq_en}), 16'h023f);
        frame(16'hffff, 16);
        frame(mk(1'b1, 3'($urandom), 2'h2, 1'b0), 16);
        give_verdict();
    end
endmodule // tb
bind apm_power_ctrl apm_power_ctrl_sva #(.RES_BITS(RES_BITS), .WAKE_CYC(WAKE_CYC)) u_sva (
    .MCLK_I(MCLK_I), .NRST_I(NRST_I), .CE_I(CE_I), .CS_N_I(CS_N_I), .SCLK_I(SCLK_I), .DIN_I(DIN_I),
    .DOUT_O(DOUT_O), .DOUT_OE_O(DOUT_OE_O), .RESULT_I(RESULT_I), .POWERED_O(POWERED_O), .HOLD_O(HOLD_O),
    .WAKING_O(WAKING_O), .POWER_MODE_O(POWER_MODE_O), .CHANNEL_ADDR_O(CHANNEL_ADDR_O),
    .SEQUENCE_ENABLE_O(SEQUENCE_ENABLE_O), .CHANNEL_MASK_O(CHANNEL_MASK_O), .FRAME_DONE_O(FRAME_DONE_O));
`default_nettype wire
